// file: design/fdf_engine.sv
// Control block field interpreter of the frame DMA engine.
// Assumes a fetcher that hands over whole blocks and a writer that stores
// the returned words two and three back to memory.
`default_nettype none

module fdf_engine (
   input  wire logic                clock,
   input  wire logic                resetn,
   input  wire logic                cb_valid,
   input  wire fdf_pkg::fdf_cb_s    cb_words,
   input  wire logic                cb_extract,
   output var  logic                cb_ready,
   output var  fdf_pkg::fdf_fields_s fields,
   output var  fdf_pkg::fdf_err_s   err,
   output var  logic                busy,
   input  wire logic                inj_release,
   input  wire logic                data_valid,
   input  wire logic                data_first,
   input  wire logic                data_last,
   output var  logic                data_ready,
   output var  logic                wb_valid,
   output var  logic [31:0]         wb_word2,
   output var  logic [31:0]         wb_word3,
   input  wire logic                wb_ready
);
   typedef struct packed {
      fdf_pkg::fdf_state_e  st;
      logic                 cb_ready;
      logic                 busy;
      fdf_pkg::fdf_fields_s fields;
      fdf_pkg::fdf_err_s    err;
      logic [31:0]          word2;
      logic [31:0]          word3;
      logic [15:0]          room;
      logic                 data_ready;
      logic                 wb_valid;
      logic [31:0]          wb_word3;
   } fdf_core_s;

   logic      rst_meta;
   logic      rst_n;
   fdf_core_s s;
   fdf_core_s next_s;
   logic      accept_cb;
   logic      accept_byte;
   logic [15:0] cap_ext;
   logic [15:0] off_ext;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // Rebuilds word three; abort and done bits pass through untouched
   function automatic logic [31:0] pack_word3(input logic [31:0] orig,
                                              input fdf_pkg::fdf_fields_s f);
      logic [31:0] w;
      w = orig;
      w[fdf_pkg::OFF_MSB:fdf_pkg::OFF_LSB] = f.frame_byte_offset;  // [R5]
      w[fdf_pkg::CNT_MSB:fdf_pkg::CNT_LSB] = f.frame_byte_count;   // [R6]
      w[fdf_pkg::SOF_BIT] = f.sof;                                 // [R7]
      w[fdf_pkg::EOF_BIT] = f.eof;                                 // [R9]
      return w;
   endfunction

   assign accept_cb   = cb_valid && s.cb_ready;
   assign accept_byte = data_valid && s.data_ready;
   assign cap_ext     = cb_words.word2[fdf_pkg::CAP_MSB:fdf_pkg::CAP_LSB];
   assign off_ext     = {4'h0, cb_words.word3[fdf_pkg::OFF_MSB:fdf_pkg::OFF_LSB]};

   always_comb begin
      next_s = s;
      case (s.st)
         fdf_pkg::FDF_IDLE: begin
            next_s.cb_ready = 1'b1;
            if (accept_cb) begin
               next_s.cb_ready = 1'b0;
               next_s.busy     = 1'b1;
               next_s.word2    = cb_words.word2;
               next_s.word3    = cb_words.word3;
               next_s.fields.next_block_pointer = cb_words.word0;            // [R8]
               next_s.fields.end_of_list = (cb_words.word0 == fdf_pkg::NULL_PTR); // [R8]
               next_s.fields.buffer_pointer = cb_words.word1;                // [R1]
               next_s.fields.sw_byte = cb_words.word2[fdf_pkg::SW_MSB:fdf_pkg::SW_LSB];
               next_s.fields.buffer_capacity = cap_ext[fdf_pkg::CAP_W-1:0];  // [R3]
               next_s.fields.frame_byte_offset =
                  cb_words.word3[fdf_pkg::OFF_MSB:fdf_pkg::OFF_LSB];         // [R5]
               next_s.err.next_unaligned =
                  (cb_words.word0[fdf_pkg::ALIGN_MSB:0] != fdf_pkg::ALIGNED); // [R8]
               // Software slips are flagged, not repaired
               next_s.err.ptr_null = (cb_words.word1 == fdf_pkg::NULL_PTR);  // [R2]
               next_s.err.ptr_unaligned =
                  (cb_words.word1[fdf_pkg::ALIGN_MSB:0] != fdf_pkg::ALIGNED); // [R2]
               next_s.err.cap_unaligned =
                  (cap_ext[fdf_pkg::ALIGN_MSB:0] != fdf_pkg::ALIGNED);       // [R4]
               next_s.room = (off_ext >= cap_ext) ? fdf_pkg::CNT_ZERO
                                                  : 16'(cap_ext - off_ext);
               if (cb_extract) begin
                  // Count and flags are ours to produce on extraction
                  next_s.fields.frame_byte_count = fdf_pkg::CNT_ZERO;        // [R10]
                  next_s.fields.sof = 1'b0;
                  next_s.fields.eof = 1'b0;
                  next_s.err.overrun = (off_ext >= cap_ext);
                  if (off_ext >= cap_ext) begin
                     next_s.st       = fdf_pkg::FDF_WB;
                     next_s.wb_valid = 1'b1;
                     next_s.wb_word3 = pack_word3(cb_words.word3, next_s.fields);
                  end else begin
                     next_s.st         = fdf_pkg::FDF_FILL;
                     next_s.data_ready = 1'b1;
                  end
               end else begin
                  next_s.fields.frame_byte_count =
                     cb_words.word3[fdf_pkg::CNT_MSB:fdf_pkg::CNT_LSB];      // [R6]
                  next_s.fields.sof = cb_words.word3[fdf_pkg::SOF_BIT];      // [R7]
                  next_s.fields.eof = cb_words.word3[fdf_pkg::EOF_BIT];      // [R9]
                  next_s.err.overrun = (17'(off_ext) +
                     17'(cb_words.word3[fdf_pkg::CNT_MSB:fdf_pkg::CNT_LSB])) > 17'(cap_ext);
                  next_s.st = fdf_pkg::FDF_HOLD;
               end
            end
         end
         fdf_pkg::FDF_FILL: begin
            if (accept_byte) begin
               next_s.fields.frame_byte_count =
                  s.fields.frame_byte_count + fdf_pkg::CNT_ONE;              // [R10]
               if (data_first) next_s.fields.sof = 1'b1;                     // [R7]
               if (data_last) next_s.fields.eof = 1'b1;                      // [R9]
               // Close on frame end or when the buffer runs out of room
               if (data_last || (next_s.fields.frame_byte_count == s.room)) begin
                  next_s.data_ready = 1'b0;
                  next_s.st         = fdf_pkg::FDF_WB;
                  next_s.wb_valid   = 1'b1;
                  next_s.wb_word3   = pack_word3(s.word3, next_s.fields);
               end
            end
         end
         fdf_pkg::FDF_WB: begin
            if (wb_ready) begin
               next_s.wb_valid = 1'b0;
               next_s.busy     = 1'b0;
               next_s.cb_ready = 1'b1;
               next_s.st       = fdf_pkg::FDF_IDLE;
            end
         end
         fdf_pkg::FDF_HOLD: begin
            if (inj_release) begin
               next_s.busy     = 1'b0;
               next_s.cb_ready = 1'b1;
               next_s.st       = fdf_pkg::FDF_IDLE;
            end
         end
         default: next_s.st = fdf_pkg::FDF_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign cb_ready   = s.cb_ready;
   assign fields     = s.fields;
   assign err        = s.err;
   assign busy       = s.busy;
   assign data_ready = s.data_ready;
   assign wb_valid   = s.wb_valid;
   assign wb_word2   = s.word2;     // Returned exactly as read [R11]
   assign wb_word3   = s.wb_word3;

   default clocking cb_clk @(posedge clock); endclocking
   default disable iff (!rst_n);

   sequence s_load;
      cb_valid && cb_ready;
   endsequence

   property p_ptr_taken;
      s_load |=> fields.buffer_pointer == $past(cb_words.word1);
   endproperty
   a_ptr_taken: assert property (p_ptr_taken) else $error("buffer pointer not taken"); // [R1]

   property p_ptr_check;
      s_load |=> err.ptr_unaligned ==
                    ($past(cb_words.word1[fdf_pkg::ALIGN_MSB:0]) != fdf_pkg::ALIGNED) &&
                 err.ptr_null == ($past(cb_words.word1) == fdf_pkg::NULL_PTR);
   endproperty
   a_ptr_check: assert property (p_ptr_check) else $error("pointer check wrong"); // [R2]

   property p_cap_taken;
      s_load |=> fields.buffer_capacity ==
                    $past(cb_words.word2[fdf_pkg::CAP_MSB:fdf_pkg::CAP_LSB]) &&
                 err.cap_unaligned ==
                    ($past(cb_words.word2[fdf_pkg::ALIGN_MSB:0]) != fdf_pkg::ALIGNED);
   endproperty
   a_cap_taken: assert property (p_cap_taken) else $error("capacity not taken"); // [R3]

   property p_wb_offset;
      $rose(wb_valid) |->
         wb_word3[fdf_pkg::OFF_MSB:fdf_pkg::OFF_LSB] == fields.frame_byte_offset &&
         wb_word3[fdf_pkg::CNT_MSB:fdf_pkg::CNT_LSB] == fields.frame_byte_count &&
         wb_word3[fdf_pkg::SOF_BIT] == fields.sof;
   endproperty
   a_wb_offset: assert property (p_wb_offset) else $error("write-back fields wrong"); // [R5]

   property p_count_step;
      data_valid && data_ready |=>
         fields.frame_byte_count == $past(fields.frame_byte_count) + fdf_pkg::CNT_ONE;
   endproperty
   a_count_step: assert property (p_count_step) else $error("byte count missed"); // [R10]

   property p_room;
      busy && !err.overrun |->
         17'(fields.frame_byte_offset) + 17'(fields.frame_byte_count) <=
         17'(fields.buffer_capacity);
   endproperty
   a_room: assert property (p_room) else $error("frame bytes exceed buffer"); // [R6]

   sequence s_first_byte;
      data_valid && data_ready && data_first;
   endsequence
   property p_sof;
      s_first_byte |=> fields.sof ##0 (wb_valid || data_ready);
   endproperty
   a_sof: assert property (p_sof) else $error("start of frame lost"); // [R7]

   property p_eof;
      data_valid && data_ready && data_last |=>
         wb_valid && wb_word3[fdf_pkg::EOF_BIT] && !data_ready;
   endproperty
   a_eof: assert property (p_eof) else $error("end of frame not written"); // [R9]

   property p_list_end;
      s_load |=> fields.end_of_list == ($past(cb_words.word0) == fdf_pkg::NULL_PTR);
   endproperty
   a_list_end: assert property (p_list_end) else $error("end of list wrong"); // [R8]

   property p_sw_byte;
      // Whole word two must come back exactly as loaded
      s_load |=> wb_word2 == $past(cb_words.word2) &&
                 fields.sw_byte == $past(cb_words.word2[fdf_pkg::SW_MSB:fdf_pkg::SW_LSB]);
   endproperty
   a_sw_byte: assert property (p_sw_byte) else $error("software byte changed"); // [R11]
endmodule // fdf_engine

`default_nettype wire

// file: common/fdf_pkg.sv
// Package for the frame DMA control block field logic.
// Assumes one 32-bit memory word per control block word, system clock only.
// How it works
// R1: Word one of a control block is the 32-bit data buffer pointer.
// R2: Software gives a non-zero buffer pointer with both low bits zero.
// R3: Word two bits 15:0 give the buffer capacity in bytes.
// R4: Software gives a capacity whose two low bits are zero.
// R5: Word three bits 31:20 give the offset to the first frame byte.
// R6: Word three bits 15:0 count frame bytes only, never offset bytes.
// R7: Word three bit 16 is one exactly when the buffer holds frame start.
// R8: Word zero points to the next block, aligned; zero ends the list.
// R9: Word three bit 17 is set when the buffer holds frame end.
// R10: On extraction the engine counts frame bytes and writes the count back.
// R11: Word two bits 31:24 are never changed by a write-back.
`default_nettype none

package fdf_pkg;
   localparam int unsigned WORD_W    = 32;
   localparam int unsigned CAP_MSB   = 15;
   localparam int unsigned CAP_LSB   = 0;
   localparam int unsigned SW_MSB    = 31;
   localparam int unsigned SW_LSB    = 24;
   localparam int unsigned OFF_MSB   = 31;
   localparam int unsigned OFF_LSB   = 20;
   localparam int unsigned CNT_MSB   = 15;
   localparam int unsigned CNT_LSB   = 0;
   localparam int unsigned SOF_BIT   = 16;
   localparam int unsigned EOF_BIT   = 17;
   localparam int unsigned ALIGN_MSB = 1;
   localparam int unsigned CAP_W     = CAP_MSB - CAP_LSB + 1;
   localparam int unsigned OFF_W     = OFF_MSB - OFF_LSB + 1;
   localparam int unsigned CNT_W     = CNT_MSB - CNT_LSB + 1;
   localparam int unsigned SW_W      = SW_MSB - SW_LSB + 1;
   localparam logic [WORD_W-1:0] NULL_PTR = 32'h0000_0000;
   localparam logic [1:0]        ALIGNED  = 2'h0;
   localparam logic [CNT_W-1:0]  CNT_ZERO = 16'h0000;
   localparam logic [CNT_W-1:0]  CNT_ONE  = 16'h0001;

   typedef enum logic [1:0] {FDF_IDLE, FDF_FILL, FDF_WB, FDF_HOLD} fdf_state_e;

   // The four words of one control block as read from memory
   typedef struct packed {
      logic [WORD_W-1:0] word3;
      logic [WORD_W-1:0] word2;
      logic [WORD_W-1:0] word1;
      logic [WORD_W-1:0] word0;
   } fdf_cb_s;

   typedef struct packed {
      logic [WORD_W-1:0] next_block_pointer;
      logic [WORD_W-1:0] buffer_pointer;
      logic [SW_W-1:0]   sw_byte;
      logic [CAP_W-1:0]  buffer_capacity;
      logic [OFF_W-1:0]  frame_byte_offset;
      logic [CNT_W-1:0]  frame_byte_count;
      logic              sof;
      logic              eof;
      logic              end_of_list;
   } fdf_fields_s;

   typedef struct packed {
      logic next_unaligned;
      logic ptr_null;
      logic ptr_unaligned;
      logic cap_unaligned;
      logic overrun;
   } fdf_err_s;
endpackage : fdf_pkg

`default_nettype wire

// file: testbench/fdf_cpu_model.sv
// CPU side model: builds control blocks and accepts write-backs.
// Assumes a bench that pulses offer for one cycle per block.
`default_nettype none

module fdf_cpu_model (
   input  wire logic                 clock,
   input  wire logic                 resetn,
   input  wire logic                 offer,
   input  wire fdf_pkg::fdf_fields_s want,
   input  wire logic                 ext,
   input  wire logic [3:0]           wb_wait,
   input  wire logic                 cb_ready,
   output var  logic                 cb_valid,
   output var  fdf_pkg::fdf_cb_s     cb_words,
   output var  logic                 cb_extract,
   input  wire logic                 wb_valid,
   output var  logic                 wb_ready
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] wait_cnt;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         cb_valid   <= 1'b0;
         cb_words   <= '0;
         cb_extract <= 1'b0;
         wb_ready   <= 1'b0;
         wait_cnt   <= 4'h0;
      end else begin
         if (cb_valid && cb_ready) begin
            cb_valid <= 1'b0;
            // Stale words must never pass for a fresh block
            cb_words <= ~cb_words;
         end else if (offer) begin
            cb_valid       <= 1'b1;
            cb_extract     <= ext;
            cb_words.word0 <= {want.next_block_pointer[31:2], 2'h0};
            cb_words.word1 <= {want.buffer_pointer[31:2], 2'h0};
            cb_words.word2 <= {want.sw_byte, 8'h00, want.buffer_capacity[15:2], 2'h0};
            cb_words.word3 <= {want.frame_byte_offset, 2'h0, want.eof, want.sof,
                               want.frame_byte_count};
         end
         // Slow acceptance: wb_wait idle cycles before wb_ready
         wb_ready <= 1'b0;
         if (wb_valid && !wb_ready) begin
            wait_cnt <= (wait_cnt == wb_wait) ? 4'h0 : wait_cnt + 4'h1;
            wb_ready <= (wait_cnt == wb_wait);
         end
      end
   end
endmodule // fdf_cpu_model

`default_nettype wire

// file: testbench/frame_dma_descriptor_fields_test.sv
// Self-checking bench for the control block field interpreter.
// Assumes fdf_cpu_model stands on the memory side of the engine.
`default_nettype none

module frame_dma_descriptor_fields_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic                 clock, resetn, offer, ext, cb_ready, cb_valid, cb_extract, busy;
   logic                 inj_release, data_valid, data_first, data_last, data_ready;
   logic                 wb_valid, wb_ready;
   logic [3:0]           wb_wait;
   logic [31:0]          wb_word2, wb_word3;
   fdf_pkg::fdf_cb_s     cb_words;
   fdf_pkg::fdf_fields_s want, fields;
   fdf_pkg::fdf_err_s    err;
   int                   bad_count = 0;
   int                   checks = 0;

   fdf_engine fdf_engine_inst (.clock(clock), .resetn(resetn), .cb_valid(cb_valid),
      .cb_words(cb_words), .cb_extract(cb_extract), .cb_ready(cb_ready), .fields(fields),
      .err(err), .busy(busy), .inj_release(inj_release), .data_valid(data_valid),
      .data_first(data_first), .data_last(data_last), .data_ready(data_ready),
      .wb_valid(wb_valid), .wb_word2(wb_word2), .wb_word3(wb_word3), .wb_ready(wb_ready));

   fdf_cpu_model fdf_cpu_model_inst (.clock(clock), .resetn(resetn), .offer(offer),
      .want(want), .ext(ext), .wb_wait(wb_wait), .cb_ready(cb_ready), .cb_valid(cb_valid),
      .cb_words(cb_words), .cb_extract(cb_extract), .wb_valid(wb_valid), .wb_ready(wb_ready));

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   task automatic chk(input logic [159:0] got, input logic [159:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic end_of_test;
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // 0 busy, 1 wb_valid, 2 cb_ready; sampled 1 ns after each edge
   task automatic wait_until(input int sel);
      int n;
      n = 0;
      #1;
      while (n < 40 && ((sel == 0) ? busy : (sel == 1) ? wb_valid : cb_ready) !== 1'b1) begin
         @(posedge clock);
         #1;
         n++;
      end
      chk(n < 40, 1'b1);
   endtask

   task automatic load(input fdf_pkg::fdf_fields_s w, input logic e, input logic [3:0] ww);
      @(posedge clock);
      want    <= w;
      ext     <= e;
      wb_wait <= ww;
      offer   <= 1'b1;
      @(posedge clock);
      offer <= 1'b0;
      wait_until(0);
   endtask

   // Called at an edge; each byte held until the edge that takes it
   task automatic send_bytes(input int cnt, input logic f, input logic l);
      logic r;
      for (int i = 0; i < cnt; i++) begin
         data_valid <= 1'b1;
         data_first <= f && (i == 0);
         data_last  <= l && (i == cnt - 1);
         r = 1'b0;
         while (!r) begin
            #1;
            r = (data_ready === 1'b1);
            @(posedge clock);
         end
      end
      data_valid <= 1'b0;
      data_first <= 1'b0;
      data_last  <= 1'b0;
   endtask

   task automatic inj_block(input fdf_pkg::fdf_fields_s w, input logic [4:0] exp_err);
      fdf_pkg::fdf_fields_s exp_f;
      exp_f = w;
      exp_f.end_of_list = (w.next_block_pointer == 32'h0000_0000);
      load(w, 1'b0, 4'h0);
      chk(fields, exp_f);
      chk(err, exp_err);
      repeat (3) @(posedge clock);
      #1;
      chk({wb_valid, busy}, 2'h1);
      @(posedge clock);
      inj_release <= 1'b1;
      @(posedge clock);
      inj_release <= 1'b0;
      wait_until(2);
   endtask

   task automatic ext_block(input fdf_pkg::fdf_fields_s w, input int n, input logic f,
                            input logic l, input logic [3:0] ww, input logic [31:0] exp3,
                            input logic [4:0] exp_err);
      load(w, 1'b1, ww);
      chk(err, exp_err);
      @(posedge clock);
      send_bytes(n, f, l);
      wait_until(1);
      chk(wb_word2, {w.sw_byte, 8'h00, w.buffer_capacity});
      chk(wb_word3, exp3);
      if (ww > 4'h2) begin
         // Write-back must stand while memory stalls
         repeat (2) @(posedge clock);
         #1;
         chk(wb_valid, 1'b1);
      end
      wait_until(2);
   endtask

   initial begin
      resetn = 1'b0;
      offer = 1'b0;
      ext = 1'b0;
      wb_wait = 4'h0;
      want = '0;
      inj_release = 1'b0;
      data_valid = 1'b0;
      data_first = 1'b0;
      data_last = 1'b0;
      repeat (8) @(posedge clock);
      resetn <= 1'b1;
      wait_until(2);
      inj_block({32'h0000_1000, 32'h0000_2000, 8'h5A, 16'h0010, 12'h004, 16'h000C,
                  1'b1, 1'b0, 1'b0}, 5'h00);
      inj_block({32'h0000_0000, 32'h0000_3004, 8'h00, 16'h0008, 12'h004, 16'h0008,
                  1'b0, 1'b1, 1'b0}, 5'h01);
      ext_block({32'h0000_1010, 32'h0000_4000, 8'hA5, 16'h0010, 12'h005, 16'h0000,
                  1'b0, 1'b0, 1'b0}, 3, 1'b1, 1'b1, 4'h0, {12'h005, 4'h3, 16'h0003},
                  5'h00);
      ext_block({32'h0000_1020, 32'h0000_5000, 8'h3C, 16'h0008, 12'h004, 16'h0000,
                  1'b0, 1'b0, 1'b0}, 4, 1'b0, 1'b0, 4'h5, {12'h004, 4'h0, 16'h0004},
                  5'h00);
      ext_block({32'h0000_1030, 32'h0000_6000, 8'hC3, 16'h0004, 12'h004, 16'h0000,
                  1'b0, 1'b0, 1'b0}, 0, 1'b0, 1'b0, 4'h2, {12'h004, 4'h0, 16'h0000},
                  5'h01);
      end_of_test();
   end

   // Whole run needs under a hundred cycles; this bound is ample
   initial begin
      repeat (4000) @(posedge clock);
      bad_count++;
      end_of_test();
   end
endmodule // frame_dma_descriptor_fields_test

`default_nettype wire
